//--- src/atf_pkg.sv
package atf_pkg;
    // ****************************************
    // offsets
    // ****************************************
    localparam logic [3:0] OFS_DATA      = 4'h0;
    localparam logic [3:0] OFS_ERRFEAT   = 4'h1;
    localparam logic [3:0] OFS_SECCNT    = 4'h2;
    localparam logic [3:0] OFS_SECNUM    = 4'h3;
    localparam logic [3:0] OFS_CYLLO     = 4'h4;
    localparam logic [3:0] OFS_CYLHI     = 4'h5;
    localparam logic [3:0] OFS_CARDHEAD  = 4'h6;
    localparam logic [3:0] OFS_STATCMD   = 4'h7;
    localparam logic [3:0] OFS_DUPDATA   = 4'h8;
    localparam logic [3:0] OFS_DUPODD    = 4'h9;
    localparam logic [3:0] OFS_DUPERR    = 4'hd;
    localparam logic [3:0] OFS_ALTSTAT   = 4'he;
    localparam logic [3:0] OFS_DRVADDR   = 4'hf;
    // ****************************************
    // address layout, register reset value, float byte and buffer depth
    // ****************************************
    localparam int         ADDR_W        = 11;
    localparam int         WIN_BIT       = 10;
    localparam int         OFS_W         = 4;
    localparam logic [7:0] REG_RST       = 8'h00;
    localparam logic [7:0] FLOAT_BYTE    = 8'hff;
    localparam int         FIFO_DEPTH    = 4;
endpackage

//--- src/atf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module atf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_ff;
    logic [AW:0]      rdPtr_ff;
    logic             doWr;
    logic             doRd;

    assign inReady  = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_ff != rdPtr_ff;
    assign outData  = mem[rdPtr_ff[AW-1:0]];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always_ff @(posedge mclk) begin
        if (doWr) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            if (doWr) begin
                wrPtr_ff <= wrPtr_ff + (AW+1)'(1);
            end
            if (doRd) begin
                rdPtr_ff <= rdPtr_ff + (AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

//--- src/atf_task_file.sv
// Behaviour
// - with both lane enables low, offset 0 is a 16-bit data word on the full bus and address bit 0 is ignored.
// - the data register at offset 0 may also be reached as two byte transfers on the low lane.
// - a low-lane byte pair to the data register moves the even byte first and the odd byte second.
// - a high-lane-only byte at offset 0 reaches error on read and features on write, not the data port.
// - offsets 8, 9 and 0xD decode as duplicates of the data and error/features registers.
// - offset 8 behaves as offset 0, and a byte access at offset 9 moves only the odd byte.
// - a byte at offset 9 followed by one at offset 8 moves the odd byte then the even byte.
// - repeated byte accesses at offset 8 or 0 step through the buffer even then odd.
// - repeated word accesses at offset 8, 9 or 0 each advance one word.
// - alternating byte accesses at 8 then 9 step through consecutive bytes even then odd.
// - address lines not used for register selection are ignored, so the set aliases.
// - in memory mode the registers sit in the common memory window of 0 to 2 KByte.
// - in memory mode even addresses 400H-7FFH act as offset 8 and odd ones as offset 9.
// - the 1 KByte window reaches the sequential data FIFO, never random buffer bytes, except that a high-lane-only byte at an even address reaches error/features.
`timescale 1ns/1ps
`default_nettype none
module atf_task_file
    import atf_pkg::*;
#(
    parameter int DEPTH = atf_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    // host bus
    input  wire logic                      regSelectN,
    input  wire logic                      memModeN,
    input  wire logic [atf_pkg::ADDR_W-1:0] hostAddr,
    input  wire logic                      low_lane_enable_n,
    input  wire logic                      high_lane_enable_n,
    input  wire logic                      io_read_strobe_n,
    input  wire logic                      io_write_strobe_n,
    input  wire logic [15:0]               hostDataIn,
    output logic      [15:0]               hostDataOut,
    output logic      [1:0]                hostDataOutEnN,
    // buffer fill side, card core to host (read data)
    input  wire logic                      rdFillValid,
    output logic                           rdFillReady,
    input  wire logic [15:0]               rdFillData,
    // buffer drain side, host to card core (write data)
    output logic                           wrDrainValid,
    input  wire logic                      wrDrainReady,
    output logic      [15:0]               wrDrainData,
    // card core status and command
    input  wire logic [7:0]                coreStatus,
    input  wire logic [7:0]                coreError,
    input  wire logic [7:0]                coreDriveAddr,
    output logic      [7:0]                cmdCode,
    output logic                           cmdStrobe,
    output logic      [7:0]                featuresReg,
    output logic      [7:0]                devControlReg,
    output logic      [7:0]                secCountReg,
    output logic      [7:0]                secNumReg,
    output logic      [7:0]                cylLoReg,
    output logic      [7:0]                cylHiReg,
    output logic      [7:0]                cardHeadReg
);
    import atf_pkg::*;

    initial begin
        if (DEPTH < 2) begin
            $error("buffer depth below 2 not supported");
        end
    end

    // ****************************************
    // access decode
    // ****************************************
    typedef enum logic [1:0] {ACC_NONE, ACC_WORD, ACC_LOW, ACC_HIGH} atf_lane_t;

    function automatic atf_lane_t laneOf(input logic ce1n, input logic ce2n);
        if (!ce1n && !ce2n) begin
            return ACC_WORD;
        end else if (!ce1n) begin
            return ACC_LOW;
        end else if (!ce2n) begin
            return ACC_HIGH;
        end
        return ACC_NONE;
    endfunction

    logic            rdStb_ff;
    logic            wrStb_ff;
    logic            inSpace;
    logic [OFS_W-1:0] ofs;
    logic            rdEdge;
    logic            wrEdge;
    atf_lane_t       lane;

    // only A3..A0 select, and in memory mode A10 picks the data window
    always_comb begin
        inSpace = !memModeN ? regSelectN : !regSelectN;
        ofs     = hostAddr[OFS_W-1:0];
        if (!memModeN && hostAddr[WIN_BIT]) begin
            ofs = hostAddr[0] ? OFS_DUPODD : OFS_DUPDATA;
        end
        // a0 is a don't-care for a word access at the data port
        if (ofs == OFS_DATA || ofs == OFS_ERRFEAT || ofs == OFS_DUPDATA) begin
            if (laneOf(low_lane_enable_n, high_lane_enable_n) == ACC_WORD) begin
                ofs = OFS_DATA;
            end
        end
    end

    assign lane   = laneOf(low_lane_enable_n, high_lane_enable_n);
    assign rdEdge = inSpace && lane != ACC_NONE && !io_read_strobe_n && !rdStb_ff;
    assign wrEdge = inSpace && lane != ACC_NONE && !io_write_strobe_n && !wrStb_ff;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdStb_ff <= 1'b0;
            wrStb_ff <= 1'b0;
        end else begin
            rdStb_ff <= inSpace && lane != ACC_NONE && !io_read_strobe_n;
            wrStb_ff <= inSpace && lane != ACC_NONE && !io_write_strobe_n;
        end
    end

    // ****************************************
    // data port classification
    // ****************************************
    logic isWordData;
    logic isEvenByte;
    logic isOddByte;

    always_comb begin
        isWordData = 1'b0;
        isEvenByte = 1'b0;
        isOddByte  = 1'b0;
        if (lane == ACC_WORD && (ofs == OFS_DATA || ofs == OFS_DUPDATA || ofs == OFS_DUPODD)) begin
            isWordData = 1'b1;
        end else if (lane == ACC_LOW && (ofs == OFS_DATA || ofs == OFS_DUPDATA)) begin
            isEvenByte = 1'b1;
        end else if (lane == ACC_LOW && ofs == OFS_DUPODD) begin
            isOddByte = 1'b1;
        end
    end

    // ****************************************
    // read buffer
    // ****************************************
    logic        rdValid;
    logic        rdPop;
    logic [15:0] rdWord;
    logic        rdEvenDone_ff;
    logic        rdOddDone_ff;
    logic        rdByteStep;
    logic        rdOddHalf;

    atf_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_rdFifo (
        .mclk     (mclk),
        .rstn     (rstn),
        .inValid  (rdFillValid),
        .inReady  (rdFillReady),
        .inData   (rdFillData),
        .outValid (rdValid),
        .outReady (rdPop),
        .outData  (rdWord)
    );

    // a second byte at 0/8 after the even half is the odd half
    assign rdOddHalf  = isOddByte || (isEvenByte && rdEvenDone_ff);
    // a word is consumed once both halves have gone out, in either order
    assign rdByteStep = rdEdge && ((rdOddHalf && rdEvenDone_ff) || (!rdOddHalf && isEvenByte && rdOddDone_ff));
    assign rdPop      = rdValid && ((rdEdge && isWordData) || rdByteStep);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdEvenDone_ff <= 1'b0;
            rdOddDone_ff  <= 1'b0;
        end else if (rdByteStep || (rdEdge && isWordData)) begin
            rdEvenDone_ff <= 1'b0;
            rdOddDone_ff  <= 1'b0;
        end else if (rdEdge && rdOddHalf) begin
            // repeated odd-only reads just replay the same half
            rdOddDone_ff  <= 1'b1;
        end else if (rdEdge && isEvenByte) begin
            rdEvenDone_ff <= 1'b1;
        end
    end

    // ****************************************
    // write buffer
    // ****************************************
    logic [7:0]  wrEven_ff;
    logic        wrHaveEven_ff;
    logic        wrHaveOdd_ff;
    logic [7:0]  wrOdd_ff;
    logic        wrPush;
    logic [15:0] wrWord;
    logic        wrFillReady;
    logic        wrOddHalf;

    assign wrOddHalf = isOddByte || (isEvenByte && wrHaveEven_ff);

    always_comb begin
        wrPush = 1'b0;
        wrWord = {hostDataIn[15:8], hostDataIn[7:0]};
        if (wrEdge && isWordData) begin
            wrPush = 1'b1;
        end else if (wrEdge && wrOddHalf && wrHaveEven_ff) begin
            wrPush = 1'b1;
            wrWord = {hostDataIn[7:0], wrEven_ff};
        end else if (wrEdge && isEvenByte && wrHaveOdd_ff) begin
            wrPush = 1'b1;
            wrWord = {wrOdd_ff, hostDataIn[7:0]};
        end
    end

    // host writes are dropped while the buffer is full; host must pace on status
    atf_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_wrFifo (
        .mclk     (mclk),
        .rstn     (rstn),
        .inValid  (wrPush),
        .inReady  (wrFillReady),
        .inData   (wrWord),
        .outValid (wrDrainValid),
        .outReady (wrDrainReady),
        .outData  (wrDrainData)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrEven_ff     <= REG_RST;
            wrOdd_ff      <= REG_RST;
            wrHaveEven_ff <= 1'b0;
            wrHaveOdd_ff  <= 1'b0;
        end else if (wrPush || (wrEdge && isWordData)) begin
            wrHaveEven_ff <= 1'b0;
            wrHaveOdd_ff  <= 1'b0;
        end else if (wrEdge && wrOddHalf) begin
            wrOdd_ff      <= hostDataIn[7:0];
            wrHaveOdd_ff  <= 1'b1;
        end else if (wrEdge && isEvenByte) begin
            wrEven_ff     <= hostDataIn[7:0];
            wrHaveEven_ff <= 1'b1;
        end
    end

    // ****************************************
    // task file registers
    // ****************************************
    logic byteErrFeat;
    assign byteErrFeat = (lane == ACC_HIGH && (ofs == OFS_DATA || ofs == OFS_DUPDATA))
                      || ofs == OFS_ERRFEAT || ofs == OFS_DUPERR;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            featuresReg   <= REG_RST;
            devControlReg <= REG_RST;
            secCountReg   <= REG_RST;
            secNumReg     <= REG_RST;
            cylLoReg      <= REG_RST;
            cylHiReg      <= REG_RST;
            cardHeadReg   <= REG_RST;
            cmdCode       <= REG_RST;
            cmdStrobe     <= 1'b0;
        end else begin
            cmdStrobe <= 1'b0;
            if (wrEdge && byteErrFeat) begin
                featuresReg <= lane == ACC_HIGH ? hostDataIn[15:8] : hostDataIn[7:0];
            end else if (wrEdge && !isWordData && !isEvenByte && !isOddByte) begin
                unique case (ofs)
                    OFS_SECCNT:   secCountReg   <= hostDataIn[7:0];
                    OFS_SECNUM:   secNumReg     <= hostDataIn[7:0];
                    OFS_CYLLO:    cylLoReg      <= hostDataIn[7:0];
                    OFS_CYLHI:    cylHiReg      <= hostDataIn[7:0];
                    OFS_CARDHEAD: cardHeadReg   <= hostDataIn[7:0];
                    OFS_STATCMD: begin
                        cmdCode   <= hostDataIn[7:0];
                        cmdStrobe <= 1'b1;
                    end
                    OFS_ALTSTAT:  devControlReg <= hostDataIn[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // read data path
    // ****************************************
    logic [7:0] rdByte;

    always_comb begin
        unique case (ofs)
            OFS_SECCNT:   rdByte = secCountReg;
            OFS_SECNUM:   rdByte = secNumReg;
            OFS_CYLLO:    rdByte = cylLoReg;
            OFS_CYLHI:    rdByte = cylHiReg;
            OFS_CARDHEAD: rdByte = cardHeadReg;
            OFS_STATCMD:  rdByte = coreStatus;
            OFS_ALTSTAT:  rdByte = coreStatus;
            OFS_DRVADDR:  rdByte = coreDriveAddr;
            default:      rdByte = FLOAT_BYTE;
        endcase
        if (byteErrFeat) begin
            rdByte = coreError;
        end else if (rdOddHalf) begin
            rdByte = rdWord[15:8];
        end else if (isEvenByte) begin
            rdByte = rdWord[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hostDataOut    <= 16'h0000;
            hostDataOutEnN <= 2'h3;
        end else if (inSpace && !io_read_strobe_n && lane != ACC_NONE) begin
            if (isWordData) begin
                hostDataOut    <= rdWord;
                hostDataOutEnN <= 2'h0;
            end else if (lane == ACC_HIGH) begin
                hostDataOut    <= {rdByte, 8'h00};
                hostDataOutEnN <= 2'h1;
            end else begin
                hostDataOut    <= {8'h00, rdByte};
                hostDataOutEnN <= 2'h2;
            end
        end else begin
            hostDataOutEnN <= 2'h3;
        end
    end
endmodule
`default_nettype wire

//--- tb/atf_task_file_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// port checker
// ********************************
module atf_task_file_properties #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic                       mclk,
    input wire logic                       rstn,
    // host bus
    input wire logic                       regSelectN,
    input wire logic                       memModeN,
    input wire logic [atf_pkg::ADDR_W-1:0] hostAddr,
    input wire logic                       low_lane_enable_n,
    input wire logic                       high_lane_enable_n,
    input wire logic                       io_read_strobe_n,
    input wire logic                       io_write_strobe_n,
    input wire logic [15:0]                hostDataIn,
    input wire logic [15:0]                hostDataOut,
    input wire logic [1:0]                 hostDataOutEnN,
    // core side
    input wire logic [7:0]                 coreStatus,
    input wire logic [7:0]                 coreError,
    input wire logic                       cmdStrobe,
    input wire logic [7:0]                 featuresReg,
    input wire logic [7:0]                 secCountReg
);
    import atf_pkg::*;
    logic       rdPrev_ff;
    logic       wrPrev_ff;
    logic       inSp;
    logic       regHit;
    logic       lowOnly;
    logic       rdTk;
    logic       wrTk;
    logic [3:0] ofs;
    assign ofs = hostAddr[OFS_W-1:0];
    assign inSp = regSelectN ^ memModeN;
    // the memory data window reaches the register set only through a high-lane byte at an even address (error/features)
    assign regHit = inSp && !(!memModeN && hostAddr[WIN_BIT]);
    assign lowOnly = !low_lane_enable_n && high_lane_enable_n;
    assign rdTk = !io_read_strobe_n && rdPrev_ff && inSp;
    assign wrTk = !io_write_strobe_n && wrPrev_ff && inSp;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdPrev_ff <= 1'b1;
            wrPrev_ff <= 1'b1;
        end else begin
            rdPrev_ff <= io_read_strobe_n;
            wrPrev_ff <= io_write_strobe_n;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    word_lanes_a:
        assert property (rdTk && !low_lane_enable_n && !high_lane_enable_n
            && (!regHit || ofs[3:1] == 3'h0 || ofs[3:1] == 3'h4) |=> hostDataOutEnN == 2'b00)
        else $error("word read not on both lanes");
    byte_lane_a:
        assert property (rdTk && regHit && lowOnly && hostAddr[2:0] == 3'h0 |=> hostDataOutEnN == 2'b10)
        else $error("data byte read not on low lane");
    error_high_a:
        assert property (rdTk && regHit && ofs == OFS_DATA && low_lane_enable_n && !high_lane_enable_n
            |=> hostDataOutEnN == 2'b01 && hostDataOut[15:8] == $past(coreError))
        else $error("high lane read at offset 0 not error");
    status_read_a:
        assert property (rdTk && regHit && lowOnly && (ofs == OFS_STATCMD || ofs == OFS_ALTSTAT)
            |=> hostDataOut[7:0] == $past(coreStatus))
        else $error("status read wrong");
    cmd_pulse_a:
        assert property (wrTk && regHit && lowOnly && ofs == OFS_STATCMD |=> cmdStrobe ##1 !cmdStrobe)
        else $error("command strobe not one cycle");
    dup_features_a:
        assert property (wrTk && regHit && lowOnly && ofs == OFS_DUPERR |=> featuresReg == $past(hostDataIn[7:0]))
        else $error("duplicate features write lost");
    count_write_a:
        assert property (wrTk && regHit && lowOnly && ofs == OFS_SECCNT |=> secCountReg == $past(hostDataIn[7:0]))
        else $error("sector count write lost");
    window_write_a:
        assert property (wrTk && !memModeN && hostAddr[WIN_BIT] |=> $stable(secCountReg) && !cmdStrobe)
        else $error("window write reached registers");
endmodule
bind atf_task_file atf_task_file_properties #(.DEPTH(DEPTH)) atf_task_file_properties_i (
    .mclk(mclk), .rstn(rstn), .regSelectN(regSelectN), .memModeN(memModeN), .hostAddr(hostAddr),
    .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
    .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOutEnN(hostDataOutEnN),
    .coreStatus(coreStatus), .coreError(coreError), .cmdStrobe(cmdStrobe),
    .featuresReg(featuresReg), .secCountReg(secCountReg)
);
`default_nettype wire

//--- tb/atf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module atf_host_model (
    // clock and read data
    input  wire logic                       mclk,
    input  wire logic [15:0]                hostDataOut,
    // host bus
    output logic                            regSelectN,
    output logic                            memModeN,
    output logic      [atf_pkg::ADDR_W-1:0] hostAddr,
    output logic                            low_lane_enable_n,
    output logic                            high_lane_enable_n,
    output logic                            io_read_strobe_n,
    output logic                            io_write_strobe_n,
    output logic      [15:0]                hostDataIn
);
    import atf_pkg::*;
    initial begin
        regSelectN = 1'b0;
        memModeN = 1'b1;
        hostAddr = '0;
        {high_lane_enable_n, low_lane_enable_n} = 2'b11;
        io_read_strobe_n = 1'b1;
        io_write_strobe_n = 1'b1;
        hostDataIn = 16'h0000;
    end
    // one access; strobe rises a full cycle before the next
    // callers never follow an odd-only byte read at offset 9 with another read at offset 9
    task automatic acc(input logic wr, input logic mem, input logic [10:0] a, input logic [1:0] ce,
                       input logic [15:0] wd, output logic [15:0] rd);
        @(negedge mclk);
        regSelectN = mem;
        memModeN = !mem;
        hostAddr = a;
        {high_lane_enable_n, low_lane_enable_n} = ce;
        hostDataIn = wd;
        if (wr) io_write_strobe_n = 1'b0;
        else io_read_strobe_n = 1'b0;
        @(negedge mclk);
        rd = hostDataOut;
        io_read_strobe_n = 1'b1;
        io_write_strobe_n = 1'b1;
        {high_lane_enable_n, low_lane_enable_n} = 2'b11;
        // released lines show garbage, not the last value
        hostAddr = ~a;
        hostDataIn = ~wd;
    endtask
endmodule
`default_nettype wire

//--- tb/atf_task_file_tb.sv
`timescale 1ns/1ps
`default_nettype none
module atf_task_file_tb;
    import atf_pkg::*;
    logic        mclk, rstn, regSelectN, memModeN, low_lane_enable_n, high_lane_enable_n;
    logic        io_read_strobe_n, io_write_strobe_n, rdFillValid, rdFillReady, wrDrainValid;
    logic        wrDrainReady, cmdStrobe;
    logic [10:0] hostAddr;
    logic [15:0] hostDataIn, hostDataOut, rdFillData, wrDrainData;
    logic [1:0]  hostDataOutEnN;
    logic [7:0]  coreStatus, coreError, coreDriveAddr, cmdCode, featuresReg, devControlReg;
    logic [7:0]  secCountReg, secNumReg, cylLoReg, cylHiReg, cardHeadReg;
    int          badCount, numChecks;
    atf_task_file atf_task_file_i (.mclk, .rstn, .regSelectN, .memModeN, .hostAddr, .low_lane_enable_n,
        .high_lane_enable_n, .io_read_strobe_n, .io_write_strobe_n, .hostDataIn, .hostDataOut,
        .hostDataOutEnN, .rdFillValid, .rdFillReady, .rdFillData, .wrDrainValid, .wrDrainReady,
        .wrDrainData, .coreStatus, .coreError, .coreDriveAddr, .cmdCode, .cmdStrobe, .featuresReg,
        .devControlReg, .secCountReg, .secNumReg, .cylLoReg, .cylHiReg, .cardHeadReg);
    atf_host_model atf_host_model_i (.mclk, .hostDataOut, .regSelectN, .memModeN, .hostAddr,
        .low_lane_enable_n, .high_lane_enable_n, .io_read_strobe_n, .io_write_strobe_n, .hostDataIn);
    always #5 mclk = ~mclk;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        numChecks++;
        if (g !== e) begin
            badCount++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask
    // only the lanes that were enabled are compared
    task automatic rd(input logic mem, input logic [10:0] a, input logic [1:0] ce, input logic [15:0] e);
        logic [15:0] v;
        logic [15:0] m;
        m = {{8{!ce[1]}}, {8{!ce[0]}}};
        atf_host_model_i.acc(1'b0, mem, a, ce, 16'h0000, v);
        chk(v & m, e & m);
    endtask
    task automatic wr(input logic mem, input logic [10:0] a, input logic [1:0] ce, input logic [15:0] d);
        logic [15:0] v;
        atf_host_model_i.acc(1'b1, mem, a, ce, d, v);
    endtask
    task automatic fill(input logic [15:0] w);
        int n;
        n = 0;
        @(negedge mclk);
        rdFillValid = 1'b1;
        rdFillData = w;
        while (rdFillReady !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        rdFillValid = 1'b0;
        rdFillData = ~w;
    endtask
    task automatic drain(input logic [15:0] e);
        int n;
        n = 0;
        @(negedge mclk);
        while (wrDrainValid !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk(wrDrainData, e);
        wrDrainReady = 1'b1;
        @(negedge mclk);
        wrDrainReady = 1'b0;
    endtask
    initial begin
        #50000;
        badCount++;
        tally_and_finish();
    end
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        rdFillValid = 1'b0;
        rdFillData = 16'h0000;
        wrDrainReady = 1'b0;
        coreStatus = 8'h5a;
        coreError = 8'h3c;
        coreDriveAddr = 8'h81;
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        chk({secCountReg, cmdCode}, 16'h0000);
        chk({14'h0000, hostDataOutEnN}, 16'h0003);
        // ********************************
        // task file registers
        // ********************************
        for (int i = 2; i < 7; i++) begin
            wr(1'b0, 11'h3f0 | 11'(i), 2'b10, 16'h00a0 + 16'(i));
            rd(1'b1, 11'h2f0 | 11'(i), 2'b10, 16'h00a0 + 16'(i));
        end
        chk({secCountReg, secNumReg}, 16'ha2a3);
        chk({cylLoReg, cylHiReg}, 16'ha4a5);
        chk({8'h00, cardHeadReg}, 16'h00a6);
        wr(1'b0, 11'h007, 2'b10, 16'h00ec);
        chk({8'h00, cmdCode}, 16'h00ec);
        rd(1'b0, 11'h007, 2'b10, 16'h005a);
        wr(1'b1, 11'h00e, 2'b10, 16'h0006);
        chk({8'h00, devControlReg}, 16'h0006);
        rd(1'b1, 11'h00e, 2'b10, 16'h005a);
        rd(1'b0, 11'h00f, 2'b10, 16'h0081);
        rd(1'b0, 11'h00a, 2'b10, 16'h00ff);
        wr(1'b0, 11'h00d, 2'b10, 16'h0011);
        chk({8'h00, featuresReg}, 16'h0011);
        rd(1'b0, 11'h00d, 2'b10, 16'h003c);
        wr(1'b0, 11'h000, 2'b01, 16'h2200);
        chk({8'h00, featuresReg}, 16'h0022);
        rd(1'b0, 11'h000, 2'b01, 16'h3c00);
        // ********************************
        // read data buffer
        // ********************************
        for (int i = 0; i < 4; i++) fill(16'h1100 + 16'(i));
        chk({15'h0000, rdFillReady}, 16'h0000);
        rd(1'b0, 11'h001, 2'b00, 16'h1100);
        rd(1'b0, 11'h008, 2'b00, 16'h1101);
        rd(1'b0, 11'h009, 2'b00, 16'h1102);
        rd(1'b1, 11'h4a6, 2'b00, 16'h1103);
        for (int i = 0; i < 4; i++) fill(16'h2211 + 16'(i) * 16'h2222);
        rd(1'b0, 11'h000, 2'b10, 16'h0011);
        rd(1'b0, 11'h000, 2'b10, 16'h0022);
        rd(1'b0, 11'h008, 2'b10, 16'h0033);
        rd(1'b0, 11'h009, 2'b10, 16'h0044);
        rd(1'b0, 11'h009, 2'b10, 16'h0066);
        rd(1'b0, 11'h008, 2'b10, 16'h0055);
        rd(1'b1, 11'h402, 2'b10, 16'h0077);
        rd(1'b1, 11'h7ff, 2'b10, 16'h0088);
        // ********************************
        // write data buffer, core stalled
        // ********************************
        wr(1'b0, 11'h000, 2'b00, 16'hbeef);
        wr(1'b0, 11'h000, 2'b10, 16'h0034);
        wr(1'b0, 11'h000, 2'b10, 16'h0012);
        wr(1'b0, 11'h008, 2'b10, 16'h0056);
        wr(1'b0, 11'h009, 2'b10, 16'h0078);
        wr(1'b0, 11'h009, 2'b10, 16'h009a);
        wr(1'b0, 11'h008, 2'b10, 16'h00bc);
        chk({15'h0000, wrDrainValid}, 16'h0001);
        wr(1'b1, 11'h404, 2'b00, 16'hdead);
        drain(16'hbeef);
        drain(16'h1234);
        drain(16'h7856);
        drain(16'h9abc);
        chk({15'h0000, wrDrainValid}, 16'h0000);
        wr(1'b1, 11'h5fe, 2'b00, 16'h4242);
        drain(16'h4242);
        chk({8'h00, secCountReg}, 16'h00a2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
